//--- pcicmd_top.sv
// Status/command word, base address decode and global register window
// What this block does
// RULE1: User-definable-features bit 22 always reads zero.
// RULE2: 66 MHz capable bit 21 always reads zero.
// RULE3: Reserved bits 20..16 and 15..10 read zero, writes ignored.
// RULE4: Fast back-to-back enable selects different-agent back-to-back as master.
// RULE5: System-error enable bit gates the SERR# driver.
// RULE6: Wait cycle control reads zero; no address/data stepping ever.
// RULE7: Parity response enable on acts on parity errors, off ignores them.
// RULE8: VGA palette snoop bit always reads zero.
// RULE9: Memory write and invalidate bit reads zero; never issued.
// RULE10: Special cycles bit is writable but special cycles are always ignored.
// RULE11: Bus master transactions start only while master enable is one.
// RULE12: Host sets master enable before the first action request.
// RULE13: Memory window answered only while memory space enable is one.
// RULE14: Host sets memory space enable before any access to the device.
// RULE15: I/O accesses never answered; I/O enable bit writable but inert.
// RULE16: Global registers at base address 10h plus offsets 0000h..00fch.
// RULE17: Each global register is one aligned 32-bit word.
// RULE18: Status/command word at configuration offset 04h via configuration cycles.
`timescale 1ns/1ps
module pcicmd_top
  import pcicmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration cycles
  input wire pcicmd_pkg::pcicmd_cfg_req_type cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // Memory and I/O cycles
  input wire pcicmd_pkg::pcicmd_bus_req_type bus_req,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  // Requests from the rest of the chip
  input wire logic mst_req,
  input wire logic mst_same_agent,
  input wire logic serr_event,
  input wire logic perr_detect,
  // Gated actions
  output logic mst_start,
  output logic fast_b2b_ok,
  output logic serr_n_o,
  output logic serr_n_oe,
  output logic perr_act,
  output pcicmd_pkg::pcicmd_enables_type enables
);
  import pcicmd_pkg::*;

  logic rst_s1_q, rst_s2_q;
  logic [31:0] cmd_q, cmd_d;
  logic [31:0] bar_q, bar_d;
  logic cfg_ack_q, cfg_ack_d, bus_ack_q, bus_ack_d;
  logic [31:0] cfg_rd_q, cfg_rd_d, bus_rd_q, bus_rd_d;
  logic mst_q, mst_d, fbb_q, fbb_d, serr_oe_q, serr_oe_d, perr_q, perr_d;
  logic mem_hit, win_wr;
  logic [31:0] win_rdata;
  logic [5:0] win_idx;

  // Byte-lane merge used on both configuration registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = (nw[b*8 +: 8] & wmask[b*8 +: 8]) | (old[b*8 +: 8] & ~wmask[b*8 +: 8]);
      end
    end
    return r;
  endfunction : lane_merge

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Window hit: BAR upper bits match, offset inside 0000h..00fch
  // Word offsets compared, so every byte lane of the last word at 0fch still decodes
  assign mem_hit = bus_req.mem && cmd_q[PCICMD_B_MEM] && // [RULE13]
                   (bus_req.addr[31:PCICMD_BAR_LOW_BITS] == bar_q[31:PCICMD_BAR_LOW_BITS]) &&
                   (bus_req.addr[PCICMD_BAR_LOW_BITS-1:2] <= PCICMD_WIN_LAST[PCICMD_BAR_LOW_BITS-1:2]); // [RULE16]
  assign win_idx = bus_req.addr[7:2]; // [RULE17]
  assign win_wr = mem_hit && bus_req.wr;

  // Configuration registers and their read path
  always_comb begin
    cmd_d = cmd_q;
    bar_d = bar_q;
    cfg_ack_d = cfg_req.rd || cfg_req.wr;
    cfg_rd_d = 32'h0000_0000;
    if (cfg_req.wr && cfg_req.addr == PCICMD_CFG_STATCMD_OFF) begin
      // Only bits 9,8,6,3..0 store; fixed and reserved stay zero
      cmd_d = lane_merge(cmd_q, cfg_req.wdata, cfg_req.be, PCICMD_WR_MASK); // [RULE18] [RULE3] [RULE10] [RULE15]
    end
    if (cfg_req.wr && cfg_req.addr == PCICMD_CFG_BAR_OFF) begin
      // Low bits hardwired zero give the 2 KB size probe
      bar_d = lane_merge(bar_q, cfg_req.wdata, cfg_req.be, 32'hffff_f800); // [RULE16]
    end
    if (cfg_req.rd) begin
      case (cfg_req.addr)
        PCICMD_CFG_STATCMD_OFF: cfg_rd_d = PCICMD_STAT_FIXED | (cmd_q & PCICMD_WR_MASK); // [RULE1] [RULE2] [RULE6] [RULE8] [RULE9]
        PCICMD_CFG_BAR_OFF: cfg_rd_d = bar_q;
        default: cfg_rd_d = 32'h0000_0000;
      endcase
    end
  end

  // Target answer; I/O cycles never claimed, special cycles never seen here
  always_comb begin
    bus_ack_d = mem_hit && (bus_req.rd || bus_req.wr); // [RULE15] [RULE13]
    bus_rd_d = (mem_hit && bus_req.rd) ? win_rdata : 32'h0000_0000;
  end

  // Gated master, fast back-to-back, SERR# and parity actions
  always_comb begin
    mst_d = mst_req && cmd_q[PCICMD_B_MST]; // [RULE11]
    fbb_d = mst_d && (mst_same_agent || cmd_q[PCICMD_B_FBB]); // [RULE4]
    serr_oe_d = serr_event && cmd_q[PCICMD_B_SERR]; // [RULE5]
    perr_d = perr_detect && cmd_q[PCICMD_B_PER]; // [RULE7]
  end

  // State and registered outputs, all on the released internal reset
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      cmd_q <= PCICMD_RESET & PCICMD_WR_MASK;
      bar_q <= PCICMD_BAR_RESET;
      cfg_ack_q <= 1'b0;
      cfg_rd_q <= 32'h0000_0000;
      bus_ack_q <= 1'b0;
      bus_rd_q <= 32'h0000_0000;
      mst_q <= 1'b0;
      fbb_q <= 1'b0;
      serr_oe_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      bar_q <= bar_d;
      cfg_ack_q <= cfg_ack_d;
      cfg_rd_q <= cfg_rd_d;
      bus_ack_q <= bus_ack_d;
      bus_rd_q <= bus_rd_d;
      mst_q <= mst_d;
      fbb_q <= fbb_d;
      serr_oe_q <= serr_oe_d;
      perr_q <= perr_d;
    end
  end

  pcicmd_regwin #(.WORDS(PCICMD_WIN_WORDS)) u_win (
    .clk(clk),
    .rst_n(rst_s2_q),
    .wr(win_wr),
    .idx(win_idx),
    .wdata(bus_req.wdata),
    .be(bus_req.be),
    .rdata(win_rdata)
  );

  // Outputs straight from flops; serr_n_o is a constant low
  assign cfg_ack = cfg_ack_q;
  assign cfg_rdata = cfg_rd_q;
  assign bus_ack = bus_ack_q;
  assign bus_rdata = bus_rd_q;
  assign mst_start = mst_q;
  assign fast_b2b_ok = fbb_q;
  assign serr_n_o = 1'b0; // Open drain: only pulls low
  assign serr_n_oe = serr_oe_q;
  assign perr_act = perr_q;
  assign enables = '{cmd_q[PCICMD_B_FBB], cmd_q[PCICMD_B_SERR], cmd_q[PCICMD_B_PER],
                     cmd_q[PCICMD_B_SPC], cmd_q[PCICMD_B_MST], cmd_q[PCICMD_B_MEM], cmd_q[PCICMD_B_IOS]};

  // Checks
  a_fixed_zero: assert property (@(posedge clk) disable iff (!rst_s2_q)
    cfg_ack && $past(cfg_req.rd) && $past(cfg_req.addr) == PCICMD_CFG_STATCMD_OFF
    |-> cfg_rdata == (PCICMD_STAT_FIXED | (cfg_rdata & PCICMD_WR_MASK))) else $error("fixed bits wrong"); // [RULE1]
  a_no_66m: assert property (@(posedge clk) disable iff (!rst_s2_q)
    cfg_ack |-> !cfg_rdata[PCICMD_B_66M] || $past(cfg_req.addr) != PCICMD_CFG_STATCMD_OFF)
    else $error("66 MHz bit set"); // [RULE2]
  a_rsvd_store: assert property (@(posedge clk) disable iff (!rst_s2_q)
    (cmd_q & ~PCICMD_WR_MASK) == 32'h0000_0000) else $error("reserved bit stored"); // [RULE3]
  a_fbb_gate: assert property (@(posedge clk) disable iff (!rst_s2_q)
    mst_req && !mst_same_agent && !cmd_q[PCICMD_B_FBB] |=> !fast_b2b_ok) else $error("fbb leak"); // [RULE4]
  a_serr_gate: assert property (@(posedge clk) disable iff (!rst_s2_q)
    serr_event && cmd_q[PCICMD_B_SERR] |=> serr_n_oe) else $error("serr not driven"); // [RULE5]
  a_serr_off: assert property (@(posedge clk) disable iff (!rst_s2_q)
    !cmd_q[PCICMD_B_SERR] |=> !serr_n_oe) else $error("serr driven while disabled"); // [RULE5]
  a_perr_gate: assert property (@(posedge clk) disable iff (!rst_s2_q)
    perr_act |-> $past(perr_detect) && $past(cmd_q[PCICMD_B_PER])) else $error("parity action wrong"); // [RULE7]
  a_mst_gate: assert property (@(posedge clk) disable iff (!rst_s2_q)
    mst_start |-> $past(cmd_q[PCICMD_B_MST]) && $past(mst_req)) else $error("master without enable"); // [RULE11]
  a_mem_gate: assert property (@(posedge clk) disable iff (!rst_s2_q)
    bus_ack |-> $past(cmd_q[PCICMD_B_MEM]) && $past(bus_req.mem)) else $error("memory answer while off"); // [RULE13]
  a_io_none: assert property (@(posedge clk) disable iff (!rst_s2_q)
    bus_req.io && !bus_req.mem |=> !bus_ack) else $error("io answered"); // [RULE15]
  a_win_rdback: assert property (@(posedge clk) disable iff (!rst_s2_q)
    win_wr && bus_req.be == 4'hf ##1 !win_wr
    ##1 mem_hit && bus_req.rd && win_idx == $past(win_idx, 2)
    |=> bus_rdata == $past(bus_req.wdata, 3)) else $error("window readback"); // [RULE17]
  a_cmd_write: assert property (@(posedge clk) disable iff (!rst_s2_q)
    cfg_req.wr && cfg_req.addr == PCICMD_CFG_STATCMD_OFF && cfg_req.be == 4'hf
    |=> cmd_q == ($past(cfg_req.wdata) & PCICMD_WR_MASK)) else $error("command write lost"); // [RULE18]
  c_mem_read: cover property (@(posedge clk) disable iff (!rst_s2_q) bus_ack && $past(bus_req.rd));
  c_mst_go: cover property (@(posedge clk) disable iff (!rst_s2_q) mst_start && fast_b2b_ok);
  c_serr: cover property (@(posedge clk) disable iff (!rst_s2_q) serr_n_oe);
  c_cfg_rd: cover property (@(posedge clk) disable iff (!rst_s2_q) cfg_ack && cfg_rdata[PCICMD_B_MEM]);
  c_io_seen: cover property (@(posedge clk) disable iff (!rst_s2_q) bus_req.io && cmd_q[PCICMD_B_IOS]);
  a_bar_low: assert property (@(posedge clk) disable iff (!rst_s2_q)
    bar_q[PCICMD_BAR_LOW_BITS-1:0] == 11'h000) else $error("base low bits stored"); // [RULE16]
  a_io_inert: assert property (@(posedge clk) disable iff (!rst_s2_q)
    bus_req.io && !bus_req.mem && cmd_q[PCICMD_B_IOS] |=> !bus_ack) else $error("io enable acted"); // [RULE15]
  a_cfg_ack: assert property (@(posedge clk) disable iff (!rst_s2_q)
    cfg_req.rd || cfg_req.wr |=> cfg_ack) else $error("config cycle not acked"); // [RULE18]
endmodule : pcicmd_top

//--- pcicmd_pkg.sv
// Package: offsets, field positions, reset values and carriers of the command decode block
package pcicmd_pkg;
  // Configuration space locations
  localparam logic [7:0] PCICMD_CFG_STATCMD_OFF = 8'h04;
  localparam logic [7:0] PCICMD_CFG_BAR_OFF = 8'h10;
  // Global register window, byte offsets
  localparam logic [15:0] PCICMD_WIN_FIRST = 16'h0000;
  localparam logic [15:0] PCICMD_WIN_LAST = 16'h00fc;
  localparam int PCICMD_WIN_WORDS = 64;
  localparam int PCICMD_BAR_LOW_BITS = 11;
  // Command word field positions
  localparam int PCICMD_B_IOS = 0;
  localparam int PCICMD_B_MEM = 1;
  localparam int PCICMD_B_MST = 2;
  localparam int PCICMD_B_SPC = 3;
  localparam int PCICMD_B_MWI = 4;
  localparam int PCICMD_B_VGA = 5;
  localparam int PCICMD_B_PER = 6;
  localparam int PCICMD_B_WCC = 7;
  localparam int PCICMD_B_SERR = 8;
  localparam int PCICMD_B_FBB = 9;
  localparam int PCICMD_B_66M = 21;
  localparam int PCICMD_B_UDF = 22;
  // Writable command bits and hardwired status half
  localparam logic [31:0] PCICMD_WR_MASK = 32'h0000_034f;
  localparam logic [31:0] PCICMD_STAT_FIXED = 32'h0280_0000;
  localparam logic [31:0] PCICMD_RESET = 32'h0280_0000;
  localparam logic [31:0] PCICMD_BAR_RESET = 32'h0000_0000;

  // Configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } pcicmd_cfg_req_type;

  // Bus-side memory or I/O access request
  typedef struct packed {
    logic mem;
    logic io;
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } pcicmd_bus_req_type;

  // Command enables handed to the rest of the chip
  typedef struct packed {
    logic fast_b2b_enable;
    logic syserr_driver_enable;
    logic parity_response_enable;
    logic special_cycle_enable;
    logic master_enable;
    logic memory_space_enable;
    logic io_space_enable;
  } pcicmd_enables_type;
endpackage : pcicmd_pkg

//--- pcicmd_regwin.sv
// Global register window: 64 aligned 32-bit words with byte lanes
`timescale 1ns/1ps
module pcicmd_regwin #(
  parameter int WORDS = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Word access
  input wire logic wr,
  input wire logic [$clog2(WORDS)-1:0] idx,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  output logic [31:0] rdata
);
  logic [31:0] mem_q [WORDS];
  logic [31:0] mem_d;

  // Byte-lane merge of the addressed word
  always_comb begin
    mem_d = mem_q[idx];
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        mem_d[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
  end

  // Storage; each global register holds a full word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= 32'h0000_0000;
      end
    end else if (wr) begin
      mem_q[idx] <= mem_d; // [RULE17]
    end
  end

  assign rdata = mem_q[idx];
endmodule : pcicmd_regwin

//--- pcicmd_host_model.sv
// Host model: issues configuration and memory cycles and collects the answers
`timescale 1ns/1ps
module pcicmd_host_model
  import pcicmd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Answers from the device
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  // Requests to the device
  output pcicmd_pkg::pcicmd_cfg_req_type cfg_req,
  output pcicmd_pkg::pcicmd_bus_req_type bus_req
);
  initial begin
    cfg_req = '0;
    bus_req = '0;
  end

  // One-cycle config pulse; released fields show the inverse so stale data cannot match
  task automatic cfg_op(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    rd = '0;
    @(negedge clk);
    cfg_req = '{rd: !w, wr: w, addr: a, wdata: d, be: 4'hf};
    @(negedge clk);
    cfg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d, be: 4'h0};
    for (int i = 0; i < 4 && !ok; i++) begin
      if (cfg_ack === 1'b1) begin
        ok = 1'b1;
        rd = cfg_rdata;
      end else @(negedge clk);
    end
  endtask : cfg_op

  // One-cycle memory or I/O pulse; a miss simply never sees an ack
  task automatic mem_op(input logic w, input logic io, input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] b, output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    rd = '0;
    @(negedge clk);
    bus_req = '{mem: !io, io: io, rd: !w, wr: w, addr: a, wdata: d, be: b};
    @(negedge clk);
    bus_req = '{mem: 1'b0, io: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d, be: 4'h0};
    for (int i = 0; i < 4 && !ok; i++) begin
      if (bus_ack === 1'b1) begin
        ok = 1'b1;
        rd = bus_rdata;
      end else @(negedge clk);
    end
  endtask : mem_op
endmodule : pcicmd_host_model

//--- pcicmd_bench.sv
// Self-checking bench for the command word, base decode and register window
`timescale 1ns/1ps
module pcicmd_bench;
  import pcicmd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mst_req = 1'b0, mst_same_agent = 1'b0, serr_event = 1'b0, perr_detect = 1'b0;
  pcicmd_cfg_req_type cfg_req;
  pcicmd_bus_req_type bus_req;
  logic cfg_ack, bus_ack, mst_start, fast_b2b_ok, serr_n_o, serr_n_oe, perr_act, ok, w;
  logic [31:0] cfg_rdata, bus_rdata, cmd_m, bar_m, rd, a;
  logic [31:0] win_m [64];
  logic [31:0] gv [4] = '{32'h0000_0000, 32'h0000_0346, 32'h0000_0204, 32'h0000_0144};
  pcicmd_enables_type enables;
  int miscompares = 0;
  int samples_checked = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  pcicmd_top dut (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .bus_req(bus_req), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .mst_req(mst_req),
    .mst_same_agent(mst_same_agent), .serr_event(serr_event), .perr_detect(perr_detect),
    .mst_start(mst_start), .fast_b2b_ok(fast_b2b_ok), .serr_n_o(serr_n_o), .serr_n_oe(serr_n_oe),
    .perr_act(perr_act), .enables(enables));
  pcicmd_host_model host (.clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .cfg_req(cfg_req), .bus_req(bus_req));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // Config cycle with model update; a missing ack ends the run
  task automatic cfg(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    host.cfg_op(wr, ad, d, rd, ok);
    if (ok !== 1'b1) begin
      check({31'h0, ok}, 32'h1);
      close_out();
    end
    if (wr && ad == 8'h04) cmd_m = (cmd_m & ~PCICMD_WR_MASK) | (d & PCICMD_WR_MASK);
    if (wr && ad == 8'h10) bar_m = d & 32'hffff_f800;
  endtask : cfg

  // Memory or I/O cycle compared with the window model
  task automatic mem(input logic wr, input logic io, input logic [31:0] ad, input logic [3:0] b,
                     input logic hit);
    logic [31:0] d;
    d = $urandom;
    host.mem_op(wr, io, ad, d, b, rd, ok);
    check({31'h0, ok}, {31'h0, hit});
    if (hit && !wr) check(rd, win_m[ad[7:2]]);
    for (int k = 0; k < 4; k++) if (hit && wr && b[k]) win_m[ad[7:2]][8*k +: 8] = d[8*k +: 8];
  endtask : mem

  initial begin
    void'($urandom(19384));
    cmd_m = PCICMD_RESET;
    bar_m = PCICMD_BAR_RESET;
    foreach (win_m[i]) win_m[i] = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    cfg(1'b0, 8'h04, 32'h0); check(rd, cmd_m);
    cfg(1'b0, 8'h10, 32'h0); check(rd, 32'h0);
    cfg(1'b0, 8'h08, 32'h0); check(rd, 32'h0);
    cfg(1'b1, 8'h04, 32'hffff_ffff); cfg(1'b0, 8'h04, 32'h0); check(rd, 32'h0280_034f);
    check(32'(enables), 32'h7f);
    cfg(1'b1, 8'h10, 32'hffff_ffff); cfg(1'b0, 8'h10, 32'h0); check(rd, 32'hffff_f800);
    // Memory enable dropped after first being set; the window must stay silent
    cfg(1'b1, 8'h04, 32'h0000_0004);
    mem(1'b0, 1'b0, bar_m, 4'hf, 1'b0);
    cfg(1'b1, 8'h04, 32'hffff_ffff);
    cfg(1'b1, 8'h10, $urandom);
    mem(1'b0, 1'b1, bar_m, 4'hf, 1'b0);
    for (int n = 0; n < 48; n++) begin
      w = n < 8 ? 1'b1 : 1'($urandom);
      a = bar_m | {24'h0, 6'($urandom), 2'($urandom)};
      mem(w, 1'b0, a, w ? 4'($urandom) : 4'hf, 1'b1);
    end
    mem(1'b0, 1'b0, bar_m + 32'h100, 4'hf, 1'b0);
    // Full-word write then read of one word, one idle cycle apart
    mem(1'b1, 1'b0, bar_m | 32'h24, 4'hf, 1'b1); mem(1'b0, 1'b0, bar_m | 32'h24, 4'hf, 1'b1);
    // Gated actions for each enable pattern, inputs held as levels
    foreach (gv[g]) begin
      cfg(1'b1, 8'h04, gv[g]);
      @(negedge clk);
      mst_same_agent = 1'($urandom);
      {mst_req, serr_event, perr_detect} = 3'b111;
      repeat (3) @(negedge clk);
      check({mst_start, fast_b2b_ok, serr_n_o, serr_n_oe, perr_act},
        {gv[g][2], gv[g][2] & (mst_same_agent | gv[g][9]), 1'b0, gv[g][8], gv[g][6]});
      {mst_req, serr_event, perr_detect} = 3'b000;
    end
    mem(1'b0, 1'b0, bar_m, 4'hf, 1'b0);
    close_out();
  end
endmodule : pcicmd_bench
